/* inc/eic_defines.vh */
// Constants for the encoder index event configuration block
// Contract
// - Bit 0 picks binary or decimal encoder constant
// - Bit 1 loads position with reset value
// - Bit 2 acts on every qualified event
// - Bit 3 acts on next qualified event only
// - Hardware clears bit 3 after one action unless bit 2 is also set
// - Bit 4 sets index active polarity
// - Bits 6:5 pick level or edge sensitivity
// - Bit 7 sets required A level
// - Bit 8 sets required B level
// - Bit 9 ignores A and B levels
// - Config register at 0x07, reset 0x00000400
// - Bit 10 latches encoder position on event
// - Bit 11 latches motor position on event
`ifndef EIC_DEFINES_VH
`define EIC_DEFINES_VH
`define EIC_IDX_CONFIG        8'h07
`define EIC_IDX_ENC_POS       8'h08
`define EIC_IDX_ENC_LATCH     8'h09
`define EIC_IDX_POS_LATCH     8'h0a
`define EIC_IDX_ENC_RESET_VAL 8'h0b
`define EIC_IDX_MOTOR_POS     8'h0c
`define EIC_CFG_RESET   32'h00000400
`define EIC_CFG_USED    12
`define EIC_B_DECIMAL   0
`define EIC_B_CLEAR     1
`define EIC_B_CONT      2
`define EIC_B_ONCE      3
`define EIC_B_POL_N     4
`define EIC_B_SENS_LO   5
`define EIC_B_SENS_HI   6
`define EIC_B_POL_A     7
`define EIC_B_POL_B     8
`define EIC_B_IGN_AB    9
`define EIC_B_LATCH_ENC 10
`define EIC_B_LATCH_X   11
`define EIC_SENS_LEVEL  2'h0
`define EIC_SENS_RISE   2'h1
`define EIC_SENS_FALL   2'h2
`define EIC_SENS_BOTH   2'h3
`endif

/* src/eic_index_event.v */
// Encoder index event qualification, position clear/latch and APB registers
//
// Design decision made here: the APB slave port.
`include "eic_defines.vh"
`default_nettype none
module eic_index_event #(
   parameter integer POS_W = 32
) (
   input  wire              I_MCLK,
   input  wire              I_RST,
   input  wire              I_PSEL,
   input  wire              I_PENABLE,
   input  wire              I_PWRITE,
   input  wire [11:0]       I_PADDR,
   input  wire [31:0]       I_PWDATA,
   output wire [31:0]       O_PRDATA,
   output wire              O_PREADY,
   output wire              O_PSLVERR,
   input  wire              I_ENC_A,
   input  wire              I_ENC_B,
   input  wire              I_ENC_N,
   input  wire [POS_W-1:0]  I_ENC_POS,
   input  wire [POS_W-1:0]  I_MOTOR_POS,
   output reg               O_ENC_POS_LOAD,
   output reg  [POS_W-1:0]  O_ENC_POS_LOAD_VAL,
   output reg               O_ENC_DECIMAL,
   output reg               O_INDEX_EVENT
);

   reg  [`EIC_CFG_USED-1:0] cfg_q;
   reg  [`EIC_CFG_USED-1:0] cfg_d;
   reg  [POS_W-1:0]         enc_latch_q;
   reg  [POS_W-1:0]         pos_latch_q;
   reg  [POS_W-1:0]         reset_val_q;
   reg                      n_prev_q;
   reg  [31:0]              rdata_q;
   reg  [31:0]              rdata_d;
   wire                     n_act;
   wire                     n_prev_act;
   reg                      sens_hit;
   wire                     ab_ok;
   wire                     qual;
   wire                     fire;
   wire                     wr_acc;
   wire                     rd_acc;
   wire                     addr_ok;

   // Full-width reset image so the stored bits are cut on purpose
   localparam [31:0]        CFG_RST = `EIC_CFG_RESET;

   function is_reg;
      input [11:0] addr;
      input [7:0]  idx;
      begin
         is_reg = (addr == {2'h0, idx, 2'h0});
      end
   endfunction

   // Single-cycle access: zero wait states
   assign O_PREADY  = 1'b1;
   assign wr_acc    = I_PSEL & I_PENABLE & I_PWRITE;
   assign rd_acc    = I_PSEL & ~I_PWRITE;
   assign addr_ok   = is_reg(I_PADDR, `EIC_IDX_CONFIG) | is_reg(I_PADDR, `EIC_IDX_ENC_POS) |
                      is_reg(I_PADDR, `EIC_IDX_ENC_LATCH) | is_reg(I_PADDR, `EIC_IDX_POS_LATCH) |
                      is_reg(I_PADDR, `EIC_IDX_ENC_RESET_VAL) | is_reg(I_PADDR, `EIC_IDX_MOTOR_POS);
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;
   assign O_PRDATA  = rdata_q;

   // Index level translated to active/inactive
   assign n_act      = ~(I_ENC_N ^ cfg_q[`EIC_B_POL_N]);
   assign n_prev_act = ~(n_prev_q ^ cfg_q[`EIC_B_POL_N]);

   always @* begin
      case (cfg_q[`EIC_B_SENS_HI:`EIC_B_SENS_LO])
         `EIC_SENS_LEVEL: sens_hit = n_act;
         `EIC_SENS_RISE:  sens_hit = n_act & ~n_prev_act;
         `EIC_SENS_FALL:  sens_hit = ~n_act & n_prev_act;
         `EIC_SENS_BOTH:  sens_hit = n_act ^ n_prev_act;
         default:         sens_hit = 1'b0;
      endcase
   end

   assign ab_ok = cfg_q[`EIC_B_IGN_AB] |
                  ((I_ENC_A == cfg_q[`EIC_B_POL_A]) &
                   (I_ENC_B == cfg_q[`EIC_B_POL_B]));
   assign qual  = sens_hit & ab_ok;
   assign fire  = qual & (cfg_q[`EIC_B_CONT] | cfg_q[`EIC_B_ONCE]);

   always @* begin
      cfg_d = cfg_q;
      if (wr_acc && is_reg(I_PADDR, `EIC_IDX_CONFIG)) begin
         cfg_d = I_PWDATA[`EIC_CFG_USED-1:0];
      end
      // Hardware clear wins over a concurrent write so the one-shot cannot re-arm
      if (fire && !cfg_q[`EIC_B_CONT]) begin
         cfg_d[`EIC_B_ONCE] = 1'b0;
      end
   end

   always @* begin
      rdata_d = 32'h00000000;
      if (is_reg(I_PADDR, `EIC_IDX_CONFIG)) begin
         rdata_d[`EIC_CFG_USED-1:0] = cfg_q;
      end else if (is_reg(I_PADDR, `EIC_IDX_ENC_POS)) begin
         rdata_d[POS_W-1:0] = I_ENC_POS;
      end else if (is_reg(I_PADDR, `EIC_IDX_ENC_LATCH)) begin
         rdata_d[POS_W-1:0] = enc_latch_q;
      end else if (is_reg(I_PADDR, `EIC_IDX_POS_LATCH)) begin
         rdata_d[POS_W-1:0] = pos_latch_q;
      end else if (is_reg(I_PADDR, `EIC_IDX_ENC_RESET_VAL)) begin
         rdata_d[POS_W-1:0] = reset_val_q;
      end else if (is_reg(I_PADDR, `EIC_IDX_MOTOR_POS)) begin
         rdata_d[POS_W-1:0] = I_MOTOR_POS;
      end
   end

   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         cfg_q              <= CFG_RST[`EIC_CFG_USED-1:0];
         enc_latch_q        <= {POS_W{1'b0}};
         pos_latch_q        <= {POS_W{1'b0}};
         reset_val_q        <= {POS_W{1'b0}};
         // Start at the inactive level so no false edge follows reset
         n_prev_q           <= ~CFG_RST[`EIC_B_POL_N];
         rdata_q            <= 32'h00000000;
         O_ENC_POS_LOAD     <= 1'b0;
         O_ENC_POS_LOAD_VAL <= {POS_W{1'b0}};
         O_ENC_DECIMAL      <= 1'b0;
         O_INDEX_EVENT      <= 1'b0;
      end else begin
         cfg_q         <= cfg_d;
         n_prev_q      <= I_ENC_N;
         O_ENC_DECIMAL <= cfg_q[`EIC_B_DECIMAL];
         O_INDEX_EVENT <= qual;
         if (rd_acc && !I_PENABLE) begin
            rdata_q <= rdata_d;
         end
         if (wr_acc && is_reg(I_PADDR, `EIC_IDX_ENC_RESET_VAL)) begin
            reset_val_q <= I_PWDATA[POS_W-1:0];
         end
         // Caller must not set the clear bit in closed loop; not enforced here
         O_ENC_POS_LOAD     <= fire & cfg_q[`EIC_B_CLEAR];
         O_ENC_POS_LOAD_VAL <= reset_val_q;
         if (fire && cfg_q[`EIC_B_LATCH_ENC]) begin
            enc_latch_q <= I_ENC_POS;
         end
         if (fire && cfg_q[`EIC_B_LATCH_X]) begin
            pos_latch_q <= I_MOTOR_POS;
         end
      end
   end

endmodule
`default_nettype wire

/* tb/eic_index_event_monitor.sv */
// Port assertions for the index event block
`default_nettype none
module eic_monitor(
   input wire logic        I_MCLK,
   input wire logic        I_RST,
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic        I_PWRITE,
   input wire logic        I_ENC_A,
   input wire logic        I_ENC_B,
   input wire logic        I_ENC_N,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic        O_PSLVERR,
   input wire logic        O_ENC_POS_LOAD,
   input wire logic        O_ENC_DECIMAL,
   input wire logic        O_INDEX_EVENT);
   timeunit 1ns; timeprecision 1ps;
   logic [11:0] c_q;
   logic n_q, act, hit, q;
   // Shadow of the config; bit3 may go stale, so no check leans on it being 1
   always @(posedge I_MCLK or posedge I_RST)
      if (I_RST) begin c_q <= 12'h400; n_q <= 1'b1; end
      else begin
         n_q <= I_ENC_N;
         if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 12'h01c) c_q <= I_PWDATA[11:0];
      end
   assign act = I_ENC_N == c_q[4];
   assign hit = c_q[6:5] == 2'h0 ? act : (n_q != I_ENC_N) && (c_q[6:5] == 2'h3 || act == (c_q[6:5] == 2'h1));
   assign q = hit && (c_q[9] || (I_ENC_A == c_q[7] && I_ENC_B == c_q[8]));
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (I_RST);
   a_qual_event: assert property (1 |=> O_INDEX_EVENT == $past(q)) else $error("event");
   a_level_mode: assert property (c_q[6:5] == 2'h0 && c_q[9] && act |=> O_INDEX_EVENT) else $error("level");
   a_a_gate: assert property (!c_q[9] && I_ENC_A != c_q[7] |=> !O_INDEX_EVENT) else $error("a gate");
   a_b_gate: assert property (!c_q[9] && I_ENC_B != c_q[8] |=> !O_INDEX_EVENT) else $error("b gate");
   a_cont_load: assert property (q && c_q[1] && c_q[2] |=> O_ENC_POS_LOAD) else $error("cont");
   a_no_clear: assert property (!c_q[1] |=> !O_ENC_POS_LOAD) else $error("clear off");
   a_no_mode: assert property (!c_q[2] && !c_q[3] |=> !O_ENC_POS_LOAD) else $error("mode off");
   a_load_cause: assert property (O_ENC_POS_LOAD |-> O_INDEX_EVENT) else $error("cause");
   a_decimal_copy: assert property (1 |=> O_ENC_DECIMAL == $past(c_q[0])) else $error("decimal");
   a_err_phase: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE) else $error("slverr");
   cover property (O_ENC_POS_LOAD);
   cover property (O_PSLVERR);
   cover property (O_INDEX_EVENT && c_q[6:5] == 2'h3);
endmodule
`default_nettype wire

/* tb/eic_enc_model.sv */
// Encoder channels, registered like real pins
`default_nettype none
module eic_enc_model(
   input  wire logic       clk,
   input  wire logic [2:0] abn,
   output logic      [2:0] pins = 3'h0);
   timeunit 1ns; timeprecision 1ps;
   always @(posedge clk) pins <= abn;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Testbench for the index event block
`default_nettype none
module tb_top;
   timeunit 1ns; timeprecision 1ps;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, se;
   logic [11:0] pa = 0;
   logic [31:0] pd = 0, rd, prdata, epos = 0, mpos = 0;
   wire  [31:0] lval;
   logic [2:0]  abn = 0, pins;
   wire         pready, pslverr, load, dec, ev;
   int          err_count, cmp_count;
   typedef struct {logic [11:0] c; logic [1:0] ab; logic n0, n1, e;} row_t;
   row_t rows[11] = '{'{12'h211,0,1,1,1}, '{12'h200,0,0,0,1}, '{12'h210,0,1,0,0}, '{12'h236,0,0,1,1},
      '{12'h236,0,1,1,0}, '{12'h256,0,1,0,1}, '{12'h272,0,1,0,1}, '{12'h070,0,0,1,1},
      '{12'h0f0,0,0,1,0}, '{12'h1f0,3,0,1,1}, '{12'h1f0,2,0,1,0}};
   eic_index_event u_dut(.I_MCLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pw), .I_PADDR(pa),
      .I_PWDATA(pd), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_ENC_A(pins[2]),
      .I_ENC_B(pins[1]), .I_ENC_N(pins[0]), .I_ENC_POS(epos), .I_MOTOR_POS(mpos), .O_ENC_POS_LOAD(load),
      .O_ENC_POS_LOAD_VAL(lval), .O_ENC_DECIMAL(dec), .O_INDEX_EVENT(ev));
   eic_enc_model u_enc(.clk(clk), .abn(abn), .pins(pins));
   always #4 clk = ~clk;
   task chk(input string n, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin err_count++; $display("[ERR] %s exp %h got %h", n, e, s); end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk); psel <= 1; pen <= 0; pw <= w; pa <= a; pd <= d;
      @(posedge clk); pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata; se = pslverr; psel <= 0; pen <= 0;
   endtask
   task drv(input logic [2:0] v, input int k);
      @(posedge clk); abn <= v;
      repeat (k) @(posedge clk);
      #1;
   endtask
   task conclude;
      $display("Checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin #20us; err_count++; conclude; end
   initial begin
      repeat (3) @(posedge clk); rst <= 0;
      apb(0, 12'h01c, 0, rd); chk("cfg reset", rd, 32'h400);
      apb(0, 12'hffc, 0, rd); chk("unmapped", rd, 32'h0);
      chk("slverr", se, 1);
      foreach (rows[i]) begin
         apb(1, 12'h01c, rows[i].c, rd);
         apb(0, 12'h01c, 0, rd); chk("cfg", rd, rows[i].c);
         drv({rows[i].ab, rows[i].n0}, 3);
         drv({rows[i].ab, rows[i].n1}, 2);
         chk("event", ev, rows[i].e);
         chk("load", load, rows[i].e & rows[i].c[1] & rows[i].c[2]);
         chk("decimal", dec, rows[i].c[0]);
      end
      // No closed loop runs here, so clear on index may be enabled
      apb(1, 12'h01c, 32'h23a, rd);
      drv(0, 3); drv(1, 2); chk("once", load, 1);
      drv(0, 3); drv(1, 2); chk("once again", load, 0);
      apb(0, 12'h01c, 0, rd); chk("once bit", rd, 32'h232);
      epos <= 32'h11; mpos <= 32'h22;
      apb(1, 12'h02c, 32'h55, rd);
      apb(1, 12'h01c, 32'hc36, rd);
      drv(0, 3); drv(1, 2); chk("cont load", load, 1);
      chk("load value", lval, 32'h55);
      apb(0, 12'h024, 0, rd); chk("enc latch", rd, 32'h11);
      apb(0, 12'h028, 0, rd); chk("pos latch", rd, 32'h22);
      @(posedge clk); rst <= 1;
      repeat (2) @(posedge clk); rst <= 0;
      repeat (2) @(posedge clk);
      #1;
      chk("event after reset", ev, 0);
      chk("load after reset", load, 0);
      apb(0, 12'h01c, 0, rd); chk("cfg after reset", rd, 32'h400);
      conclude;
   end
endmodule
bind eic_index_event eic_monitor u_mon(.*);
`default_nettype wire
